/* File: smsp_top.sv */
// Serial peripheral port, master or slave, with a classic Wishbone register slave.
// It assumes pins arrive asynchronously and are synchronised here; one clock domain.
// Notes on behaviour
// - Master bit selects master, else slave.
// - Low select input in master drops master, flags.
// - Polarity bit sets idle level of clock.
// - Phase bit picks sample or setup edge.
// - Rate and double bits divide clock in master.
// - Transfer end sets flag; interrupt when enabled.
// - Interrupt vector taken clears transfer flag.
// - Status read then data access clears flag.
// - Data write during transfer sets collision flag.
// - Status read then data access clears both.
// - Reserved status bits read as zero.
// - Double speed gives two-cycle shortest period.
// - Data write loads shifter, starts transfer in master.
// - Data read returns receive buffer.
// - Shift out, latch in on opposite edges.
// - No transfer unless enable bit set.
// - Bit order one sends LSB first.
// - Select high resets slave, drops partial byte.
// - Interrupt enable gates flag onto interrupt.
`default_nettype none
module smsp_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic global_irq_enable_i,
  input wire logic irq_taken_i,
  output logic irq_o,
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe_n_o,
  input wire logic mosi_i,
  output logic mosi_o,
  output logic mosi_oe_n_o,
  input wire logic miso_i,
  output logic miso_o,
  output logic miso_oe_n_o,
  input wire logic ss_n_i
);
  logic [7:0] ctrl;
  logic double_speed;
  logic ss_is_input;
  logic flag_done;
  logic flag_write_collision_flag;
  logic arm_done;
  logic arm_write_collision_flag;
  logic [7:0] rx_buf;
  logic [7:0] tx_sr;
  logic [7:0] rx_sr;
  logic [2:0] bit_cnt;
  logic [3:0] edge_cnt;
  logic [6:0] half_cnt;
  logic [9:0] dly;
  logic m_busy;
  logic sck_q;
  logic sck_p;
  logic [3:0] s1;
  logic [3:0] s2;
  logic [3:0] s3;
  logic [3:0] pin_f;

  // Pins pass three flops; a change counts once the second and third agree.
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          s1[gi] <= 1'b0;
          s2[gi] <= 1'b0;
          s3[gi] <= 1'b0;
          pin_f[gi] <= (gi == 3);
        end else begin
          s1[gi] <= (gi == 0) ? sck_i : (gi == 1) ? mosi_i : (gi == 2) ? miso_i : ss_n_i;
          s2[gi] <= s1[gi];
          s3[gi] <= s2[gi];
          if (s2[gi] == s3[gi]) begin
            pin_f[gi] <= s3[gi];
          end
        end
      end
    end
  endgenerate

  // Reverse a byte so that the shifter always leaves from bit seven.
  function automatic logic [7:0] smsp_rev(input logic [7:0] d);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      r[i] = d[7 - i];
    end
    return r;
  endfunction : smsp_rev

  // Decoded control fields and bus strobes.
  logic en;
  logic master;
  logic clock_polarity;
  logic clock_phase;
  logic lsb_first;
  logic req;
  logic acc;
  logic wr;
  logic data_acc;
  logic wr_data;
  assign en = ctrl[smsp_pkg::ENABLE_BIT];
  assign master = ctrl[smsp_pkg::MASTER_BIT];
  assign clock_polarity = ctrl[smsp_pkg::CLOCK_POLARITY_BIT];
  assign clock_phase = ctrl[smsp_pkg::CLOCK_PHASE_BIT];
  assign lsb_first = ctrl[smsp_pkg::BIT_ORDER_BIT];
  assign req = wb_cyc_i && wb_stb_i;
  assign acc = req && wb_ack_o;
  assign wr = acc && wb_we_i && wb_sel_i[0];
  assign data_acc = acc && (wb_adr_i == smsp_pkg::DATA_OFF);
  assign wr_data = wr && (wb_adr_i == smsp_pkg::DATA_OFF);

  // Half period from the rate code and the double speed bit.
  logic [6:0] half;
  always_comb begin
    unique case ({double_speed, ctrl[1:0]})
      3'b000: half = smsp_pkg::HALF_DIV4;
      3'b001: half = smsp_pkg::HALF_DIV16;
      3'b010: half = smsp_pkg::HALF_DIV64;
      3'b011: half = smsp_pkg::HALF_DIV128;
      3'b100: half = smsp_pkg::HALF_DIV2;
      3'b101: half = smsp_pkg::HALF_DIV8;
      3'b110: half = smsp_pkg::HALF_DIV32;
      default: half = smsp_pkg::HALF_DIV64;
    endcase
  end

  // Edge events from the master divider or from the external clock.
  logic sck_f;
  logic ss_f;
  logic sdi;
  logic slave_act;
  logic tick;
  logic s_edge;
  logic lead_e;
  logic trail_e;
  logic sample_e;
  logic setup_e;
  logic busy;
  logic done;
  logic fault;
  logic [7:0] next_rx;
  logic cap_e;
  assign sck_f = pin_f[0];
  assign ss_f = pin_f[3];
  assign sdi = master ? pin_f[2] : pin_f[1];
  assign slave_act = en && !master && !ss_f;
  assign tick = m_busy && (half_cnt == half - 7'h01);
  assign s_edge = slave_act && (sck_f != sck_p);
  // Leading edge leaves the idle level, trailing edge returns to it.
  assign lead_e = master ? (tick && !edge_cnt[0]) : (s_edge && (sck_f != clock_polarity));
  assign trail_e = master ? (tick && edge_cnt[0]) : (s_edge && (sck_f == clock_polarity));
  // Phase zero samples on leading edges; phase one sets up on them first.
  assign sample_e = clock_phase ? trail_e : lead_e;
  assign setup_e = clock_phase ? (lead_e && bit_cnt != 3'h0) : trail_e;
  assign busy = master ? (m_busy || dly[9:5] != 5'h00) : (slave_act && bit_cnt != 3'h0);
  assign done = master ? dly[9] : (sample_e && bit_cnt == smsp_pkg::LAST_BIT);
  assign fault = en && master && ss_is_input && !ss_f;
  assign next_rx = {rx_sr[6:0], sdi};
  assign cap_e = master ? dly[4] : sample_e;  // Master reads miso after its sync delay.

  // Control, status and configuration registers written by software.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= smsp_pkg::CTRL_RST;
      double_speed <= smsp_pkg::DOUBLE_SPEED_RST;
      ss_is_input <= smsp_pkg::SS_INPUT_RST;
    end else begin
      if (wr && wb_adr_i == smsp_pkg::CTRL_OFF) begin
        ctrl <= wb_dat_i[7:0];
      end
      if (wr && wb_adr_i == smsp_pkg::STAT_OFF) begin
        double_speed <= wb_dat_i[smsp_pkg::DOUBLE_SPEED_BIT];
      end
      if (wr && wb_adr_i == smsp_pkg::CFG_OFF) begin
        ss_is_input <= wb_dat_i[smsp_pkg::SS_INPUT_BIT];
      end
      // A fault outranks a same-cycle write so a contending master is never driven.
      if (fault) begin
        ctrl[smsp_pkg::MASTER_BIT] <= 1'b0;
      end
    end
  end

  // Shift engine shared by master and slave.
  always_ff @(posedge clk_i) begin
    if (rst_i || !en) begin
      m_busy <= 1'b0;
      half_cnt <= 7'h00;
      edge_cnt <= 4'h0;
      bit_cnt <= 3'h0;
      dly <= 10'h000;
      sck_q <= clock_polarity;
      tx_sr <= 8'h00;
      rx_sr <= 8'h00;
    end else begin
      // Master capture and end wait five cycles: pin output register plus miso synchroniser.
      dly <= {dly[8:5], tick && edge_cnt == smsp_pkg::LAST_EDGE, dly[3:0], master && sample_e};
      if (fault || (!master && !slave_act)) begin
        // Select high clears the slave state at once; partial bytes are lost.
        m_busy <= 1'b0;
        bit_cnt <= 3'h0;
        edge_cnt <= 4'h0;
        half_cnt <= 7'h00;
        sck_q <= clock_polarity;
      end else begin
        if (m_busy) begin
          half_cnt <= tick ? 7'h00 : half_cnt + 7'h01;
          if (tick) begin
            sck_q <= ~sck_q;
            edge_cnt <= edge_cnt + 4'h1;
            m_busy <= (edge_cnt != smsp_pkg::LAST_EDGE);
          end
        end else begin
          sck_q <= clock_polarity;
        end
        if (sample_e) begin
          bit_cnt <= bit_cnt + 3'h1;
        end
        rx_sr <= cap_e ? next_rx : rx_sr;
      end
      if (setup_e) begin
        tx_sr <= {tx_sr[6:0], 1'b0};
      end
      if (wr_data && !busy) begin
        // The shifter always leaves from bit seven, so LSB-first data is stored reversed.
        tx_sr <= lsb_first ? smsp_rev(wb_dat_i[7:0]) : wb_dat_i[7:0];
        if (master && !fault) begin
          m_busy <= 1'b1;
          half_cnt <= 7'h00;
          edge_cnt <= 4'h0;
          bit_cnt <= 3'h0;
        end
      end
    end
  end

  // Previous external clock level for slave edge detection.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sck_p <= 1'b0;
    end else begin
      sck_p <= sck_f;
    end
  end

  // Receive buffer, loaded with the completed byte in its natural order.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_buf <= 8'h00;
    end else if (en && done) begin
      rx_buf <= lsb_first ? smsp_rev(cap_e ? next_rx : rx_sr) :
                (cap_e ? next_rx : rx_sr);
    end
  end

  // Flags: a setting event always beats a clear in the same cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_done <= 1'b0;
      flag_write_collision_flag <= 1'b0;
      arm_done <= 1'b0;
      arm_write_collision_flag <= 1'b0;
    end else begin
      flag_done <= (en && done) || fault ||
                   (flag_done && !(irq_taken_i || (data_acc && (arm_done || arm_write_collision_flag))));
      flag_write_collision_flag <= (wr_data && busy) || (flag_write_collision_flag && !(data_acc && arm_write_collision_flag));
      if (acc && !wb_we_i && wb_adr_i == smsp_pkg::STAT_OFF) begin
        arm_done <= flag_done;
        arm_write_collision_flag <= flag_write_collision_flag;
      end else if (data_acc) begin
        arm_done <= 1'b0;
        arm_write_collision_flag <= 1'b0;
      end
    end
  end

  // Interrupt request, gated by the local and global enables.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= flag_done && ctrl[smsp_pkg::IRQ_EN_BIT] && global_irq_enable_i;
    end
  end

  // Bus slave: ack one cycle after the request, read data latched with it.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req && !wb_ack_o;
      if (req && !wb_ack_o) begin
        unique case (wb_adr_i)
          smsp_pkg::CTRL_OFF: wb_dat_o <= {24'h00_0000, ctrl};
          smsp_pkg::STAT_OFF: wb_dat_o <= {24'h00_0000, flag_done, flag_write_collision_flag, 5'h00,
                                           double_speed};
          smsp_pkg::DATA_OFF: wb_dat_o <= {24'h00_0000, rx_buf};
          smsp_pkg::CFG_OFF: wb_dat_o <= {31'h0000_0000, ss_is_input};
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Pin drivers; enables are active low while this end drives the pin.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sck_o <= 1'b0;
      sck_oe_n_o <= 1'b1;
      mosi_o <= 1'b0;
      mosi_oe_n_o <= 1'b1;
      miso_o <= 1'b0;
      miso_oe_n_o <= 1'b1;
    end else begin
      sck_o <= sck_q;
      sck_oe_n_o <= !(en && master && !fault);
      mosi_o <= tx_sr[7];
      mosi_oe_n_o <= !(en && master && !fault);
      miso_o <= tx_sr[7];
      miso_oe_n_o <= !slave_act;
    end
  end
endmodule : smsp_top
`default_nettype wire

/* File: smsp_pkg.sv */
// Package for the serial peripheral port: register offsets, bit positions and reset values.
// It assumes a 32-bit classic Wishbone slave decoding word offsets in byte addresses.
`default_nettype none
package smsp_pkg;
  // Register byte offsets.
  localparam logic [3:0] CTRL_OFF = 4'h0;
  localparam logic [3:0] STAT_OFF = 4'h4;
  localparam logic [3:0] DATA_OFF = 4'h8;
  localparam logic [3:0] CFG_OFF = 4'hC;
  // Control register field positions.
  localparam int IRQ_EN_BIT = 7;
  localparam int ENABLE_BIT = 6;
  localparam int BIT_ORDER_BIT = 5;
  localparam int MASTER_BIT = 4;
  localparam int CLOCK_POLARITY_BIT = 3;
  localparam int CLOCK_PHASE_BIT = 2;
  // Status register field positions.
  localparam int FLAG_DONE_BIT = 7;
  localparam int FLAG_WRITE_COLLISION_FLAG_BIT = 6;
  localparam int DOUBLE_SPEED_BIT = 0;
  // Configuration register field position.
  localparam int SS_INPUT_BIT = 0;
  // Values after reset.
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic DOUBLE_SPEED_RST = 1'b0;
  localparam logic SS_INPUT_RST = 1'b1;
  // Half periods of the serial clock in I/O clock cycles, indexed by {double, rate}.
  localparam logic [6:0] HALF_DIV4 = 7'h02;
  localparam logic [6:0] HALF_DIV16 = 7'h08;
  localparam logic [6:0] HALF_DIV64 = 7'h20;
  localparam logic [6:0] HALF_DIV128 = 7'h40;
  localparam logic [6:0] HALF_DIV2 = 7'h01;
  localparam logic [6:0] HALF_DIV8 = 7'h04;
  localparam logic [6:0] HALF_DIV32 = 7'h10;
  // Last clock edge index in one byte transfer and the last bit index.
  localparam logic [3:0] LAST_EDGE = 4'hF;
  localparam logic [2:0] LAST_BIT = 3'h7;
endpackage : smsp_pkg
`default_nettype wire

/* File: smsp_asserts.sv */
// Checker for the serial port: bus answer, interrupt gating and pin drive.
// Assumes it is bound to smsp_top and sees only that module's ports.
`default_nettype none
module smsp_asserts (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic global_irq_enable_i,
  input wire logic irq_taken_i,
  input wire logic irq_o,
  input wire logic sck_oe_n_o,
  input wire logic mosi_oe_n_o,
  input wire logic miso_oe_n_o,
  input wire logic ss_n_i
);
  // One clock domain, so reset masks every check in one place.
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_next: assert property (p_ack_next) else $error("no ack");
  property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack too long");
  property p_resv; wb_ack_o && !wb_we_i && wb_adr_i == smsp_pkg::STAT_OFF
    |-> wb_dat_o[5:1] == 5'h00 && wb_dat_o[31:8] == 24'h000000; endproperty
  a_resv: assert property (p_resv) else $error("reserved bits set");
  property p_irq_gate; irq_o |-> $past(global_irq_enable_i); endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq ungated");
  property p_irq_off; !global_irq_enable_i |=> !irq_o; endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq while off");
  property p_irq_clear; irq_taken_i |-> ##2 !irq_o; endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("irq not cleared");
  property p_oe_pair; sck_oe_n_o == mosi_oe_n_o; endproperty
  a_oe_pair: assert property (p_oe_pair) else $error("clock and data drive differ");
  property p_oe_excl; !miso_oe_n_o |-> sck_oe_n_o; endproperty
  a_oe_excl: assert property (p_oe_excl) else $error("master and slave drive");
  property p_desel; ss_n_i [*6] |-> miso_oe_n_o; endproperty
  a_desel: assert property (p_desel) else $error("drives while deselected");
endmodule : smsp_asserts
bind smsp_top smsp_asserts smsp_asserts_inst (.*);
`default_nettype wire

/* File: smsp_slave_model.sv */
// Behavioural external slave: one byte out and one in per selected frame.
// Assumes the bench sets mode, order and byte before raising select.
`default_nettype none
module smsp_slave_model (
  input wire logic sck_i,
  input wire logic mosi_i,
  input wire logic sel_i,
  input wire logic clock_polarity_i,
  input wire logic clock_phase_i,
  input wire logic lsb_i,
  input wire logic [7:0] tx_i,
  output logic miso_o,
  output logic [7:0] rx_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;
  logic out = 1'b0;
  // A released line shows the inverse, so stale data never looks valid.
  assign miso_o = sel_i ? out : ~out;
  // Select presents the first bit before any edge, as phase zero needs.
  always @(posedge sel_i) begin
    cnt = 0;
    out = lsb_i ? tx_i[0] : tx_i[7];
  end
  // Sample on the leading edge for phase zero, else the trailing; set up on the other.
  always @(sck_i) begin
    if (sel_i && (sck_i ^ clock_polarity_i ^ clock_phase_i)) begin
      rx_o = lsb_i ? {mosi_i, rx_o[7:1]} : {rx_o[6:0], mosi_i};
      cnt++;
    end else if (sel_i && cnt < 8) begin
      out = lsb_i ? tx_i[cnt] : tx_i[7 - cnt];
    end
  end
endmodule : smsp_slave_model
`default_nettype wire

/* File: smsp_top_bench.sv */
// Self-checking bench for smsp_top as master against a behavioural slave.
// Assumes one 25 MHz clock; the bench is the Wishbone master.
`default_nettype none
module smsp_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [3:0] CT = smsp_pkg::CTRL_OFF;
  localparam logic [3:0] ST = smsp_pkg::STAT_OFF;
  localparam logic [3:0] DT = smsp_pkg::DATA_OFF;
  logic clk_i, rst_i, cyc, stb, we, ack, glob, taken, irq, ss_n, psel, clock_polarity, clock_phase, lsb;
  logic sck_o, sck_oe_n, mosi_o, mosi_oe_n, miso;
  logic [3:0] adr;
  logic [31:0] wdat, rdat;
  logic [7:0] ptx, prx, rd;
  int num_errors, checked, cycles;
  int dv[8] = '{4, 16, 64, 128, 2, 8, 32, 64};
  // Released clock rests at idle; released data shows the inverse.
  wire sck = sck_oe_n ? clock_polarity : sck_o;
  wire mosi = mosi_oe_n ? ~mosi_o : mosi_o;
  smsp_top smsp_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hF), .wb_dat_o(rdat),
    .wb_ack_o(ack), .global_irq_enable_i(glob), .irq_taken_i(taken), .irq_o(irq),
    .sck_i(sck), .sck_o(sck_o), .sck_oe_n_o(sck_oe_n), .mosi_i(mosi), .mosi_o(mosi_o),
    .mosi_oe_n_o(mosi_oe_n), .miso_i(miso), .miso_o(), .miso_oe_n_o(), .ss_n_i(ss_n));
  smsp_slave_model smsp_slave_model_inst (.sck_i(sck), .mosi_i(mosi), .sel_i(psel),
    .clock_polarity_i(clock_polarity), .clock_phase_i(clock_phase), .lsb_i(lsb), .tx_i(ptx), .miso_o(miso), .rx_o(prx));
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // Hang guard; all tests need far fewer cycles.
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      results();
    end
  end
  task automatic results();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  // Request is held until ack is sampled, then released for a cycle.
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h000000, d};
    // Ack is looked at mid-cycle, where it is settled, and honoured at the next edge.
    do @(negedge clk_i); while (ack !== 1'b1);
    @(posedge clk_i);
    rd = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : bus
  task automatic wait_done();
    rd = 8'h00;
    while (rd[7] !== 1'b1) bus(1'b0, ST, 8'h00);
  endtask : wait_done
  task automatic xfer(input logic [1:0] md, input logic lo, input logic [2:0] sp);
    logic [7:0] d;
    int n;
    d = 8'($urandom);
    ptx <= 8'($urandom);
    clock_polarity <= md[1];
    clock_phase <= md[0];
    lsb <= lo;
    bus(1'b1, ST, {7'h00, sp[2]});
    bus(1'b1, CT, {2'b01, lo, 1'b1, md, sp[1:0]});
    // Let the clock settle at its new idle level before the slave is selected.
    repeat (3) @(posedge clk_i);
    psel <= 1'b1;
    bus(1'b1, DT, d);
    n = 0;
    while (sck === md[1]) @(negedge clk_i);
    while (sck !== md[1]) begin
      n++;
      @(negedge clk_i);
    end
    chk(8'(n), 8'(dv[sp] / 2));
    wait_done();
    bus(1'b0, DT, 8'h00);
    chk(rd, ptx);
    chk(prx, d);
    bus(1'b0, ST, 8'h00);
    chk(rd, {7'h00, sp[2]});
    chk({7'h00, sck}, {7'h00, md[1]});
    psel <= 1'b0;
    $display("transfer mode %0d done", md);
  endtask : xfer
  initial begin
    {cyc, stb, we, glob, taken, psel, clock_polarity, clock_phase, lsb} = '0;
    ss_n = 1'b1;
    adr = 4'h0;
    wdat = '0;
    ptx = '0;
    rst_i = 1'b1;
    void'($urandom(32'hB8AC));
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(1'b0, CT, 8'h00);
    chk(rd, smsp_pkg::CTRL_RST);
    bus(1'b0, smsp_pkg::CFG_OFF, 8'h00);
    chk(rd, 8'h01);
    bus(1'b0, 4'h2, 8'h00);
    chk(rd, 8'h00);
    $display("reset test done");
    for (int i = 0; i < 12; i++) begin
      xfer(i < 4 ? i[1:0] : 2'($urandom), 1'($urandom), i == 4 ? 3'h4 : 3'($urandom));
    end
    // Second write mid-transfer collides and is dropped.
    bus(1'b1, ST, 8'h00);
    {clock_polarity, clock_phase, lsb} <= 3'b000;
    bus(1'b1, CT, 8'hD3);
    repeat (3) @(posedge clk_i);
    psel <= 1'b1;
    bus(1'b1, DT, 8'hA5);
    bus(1'b1, DT, 8'h3C);
    wait_done();
    chk(rd, 8'hC0);
    chk(prx, 8'hA5);
    chk({7'h00, irq}, 8'h00);
    glob <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk({7'h00, irq}, 8'h01);
    taken <= 1'b1;
    @(posedge clk_i);
    taken <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk({7'h00, irq}, 8'h00);
    bus(1'b0, ST, 8'h00);
    chk(rd, 8'h40);
    bus(1'b0, DT, 8'h00);
    bus(1'b0, ST, 8'h00);
    chk(rd, 8'h00);
    psel <= 1'b0;
    bus(1'b1, CT, 8'h13);
    bus(1'b1, DT, 8'h55);
    repeat (300) @(posedge clk_i);
    bus(1'b0, ST, 8'h00);
    chk(rd, 8'h00);
    // Select pulled low in master mode drops master and flags it.
    bus(1'b1, CT, 8'h50);
    ss_n <= 1'b0;
    repeat (8) @(posedge clk_i);
    ss_n <= 1'b1;
    bus(1'b0, CT, 8'h00);
    chk(rd, 8'h40);
    bus(1'b0, ST, 8'h00);
    chk(rd, 8'h80);
    $display("flag tests done");
    results();
  end
endmodule : smsp_top_bench
`default_nettype wire
